// ---- core/rsl_defines.svh ----
// register offsets, field positions and reset values of the receive slip / loopback irq block
// assumes a 12-bit apb byte address and 32-bit data
`ifndef RSL_DEFINES_SVH
`define RSL_DEFINES_SVH

// byte offsets
`define RSL_SLIP_STAT_OFS   12'h000
`define RSL_SLIP_EN_OFS     12'h004
`define RSL_LOOP_STAT_OFS   12'h008
`define RSL_LOOP_EN_OFS     12'h00c
`define RSL_LOOP_CTRL_OFS   12'h010

// slip status / enable fields
`define RSL_FULL_BIT        2
`define RSL_EMPTY_BIT       1
`define RSL_SLIP_BIT        0

// loopback code status fields
`define RSL_UP_PRESENT_BIT  3
`define RSL_DOWN_PRESENT_BIT 2
`define RSL_UP_CHANGE_BIT   1
`define RSL_DOWN_CHANGE_BIT 0

// loopback detection control fields
`define RSL_UP_DET_EN_BIT   1
`define RSL_DOWN_DET_EN_BIT 0

// reset values
`define RSL_SLIP_EN_RST     3'h0
`define RSL_LOOP_EN_RST     2'h0
`define RSL_LOOP_CTRL_RST   2'h0

// elastic store depth in frames and occupancy after reset
`define RSL_SB_FRAMES       2'h2
`define RSL_SB_RESET_OCC    2'h1

`endif

// ---- core/rsl_pkg.sv ----
// types shared by the receive slip / loopback irq block
// assumes rsl_defines.svh for the offsets
`include "rsl_defines.svh"

package rsl_pkg;

  typedef logic [2:0] rsl_slip_bits_t;
  typedef logic [3:0] rsl_loop_bits_t;

  typedef enum logic [2:0] {
    RSL_SEL_NONE,
    RSL_SEL_SLIP_STAT,
    RSL_SEL_SLIP_EN,
    RSL_SEL_LOOP_STAT,
    RSL_SEL_LOOP_EN,
    RSL_SEL_LOOP_CTRL
  } rsl_sel_t;

  // address decode, used at setup and latched into sel_q for the access phase
  function automatic rsl_sel_t rsl_decode(input logic [11:0] addr);
    unique case (addr)
      `RSL_SLIP_STAT_OFS: rsl_decode = RSL_SEL_SLIP_STAT;
      `RSL_SLIP_EN_OFS:   rsl_decode = RSL_SEL_SLIP_EN;
      `RSL_LOOP_STAT_OFS: rsl_decode = RSL_SEL_LOOP_STAT;
      `RSL_LOOP_EN_OFS:   rsl_decode = RSL_SEL_LOOP_EN;
      `RSL_LOOP_CTRL_OFS: rsl_decode = RSL_SEL_LOOP_CTRL;
      default:            rsl_decode = RSL_SEL_NONE;
    endcase
  endfunction : rsl_decode

endpackage : rsl_pkg

// ---- core/rsl_slip_ctrl.sv ----
// frame-level occupancy of the two-frame receive elastic store
// assumes one-cycle frame write / frame read pulses synchronous to clk
`timescale 1ns/10ps
`include "rsl_defines.svh"

module rsl_slip_ctrl (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // frame events
  input  wire logic wr_frame,
  input  wire logic rd_frame,
  // slip events
  output logic      full_evt,
  output logic      empty_evt,
  output logic      frame_discard,
  output logic      frame_replay
);
  import rsl_pkg::*;

  logic [1:0] occ;
  logic [1:0] next_occ;
  logic       discard;
  logic       replay;

  // simultaneous write and read never slips
  always_comb begin
    discard  = wr_frame && !rd_frame && (occ == `RSL_SB_FRAMES);
    replay   = rd_frame && !wr_frame && (occ == 2'h0);
    next_occ = occ;
    if (wr_frame && !rd_frame && !discard) begin
      next_occ = occ + 2'h1;
    end else if (rd_frame && !wr_frame && !replay) begin
      next_occ = occ - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      occ           <= `RSL_SB_RESET_OCC;
      full_evt      <= 1'b0;
      empty_evt     <= 1'b0;
      frame_discard <= 1'b0;
      frame_replay  <= 1'b0;
    end else begin
      occ           <= next_occ;
      full_evt      <= (next_occ == `RSL_SB_FRAMES) && (occ != `RSL_SB_FRAMES);
      empty_evt     <= (next_occ == 2'h0) && (occ != 2'h0);
      frame_discard <= discard;
      frame_replay  <= replay;
    end
  end

endmodule : rsl_slip_ctrl

// ---- core/rsl_code_track.sv ----
// tracks presence of one loopback code and flags each change
// assumes the framer match level is synchronous to clk
`timescale 1ns/10ps

module rsl_code_track (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // detection
  input  wire logic code_match,
  input  wire logic det_en,
  // state
  output logic      present,
  output logic      change
);
  import rsl_pkg::*;

  logic next_present;

  always_comb begin
    next_present = code_match && det_en;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      present <= 1'b0;
      change  <= 1'b0;
    end else begin
      present <= next_present;
      change  <= next_present != present;
    end
  end

endmodule : rsl_code_track

// ---- core/rsl_irq_top.sv ----
// receive slip and loopback code interrupt block with apb register slave
// assumes framer pulses and levels synchronous to clk; apb master on the same clock
//
// Behaviour
// - store becoming full sets the full status bit, gated by its enable; the code sets it whatever the enable, which gates only irq
// - write into a full store discards one frame and sets the slip bit
// - read from an empty store replays one frame and sets the slip bit
// - store becoming empty sets the empty status bit, gated by its enable; the code sets it whatever the enable, which gates only irq
// - slip status bit rises on either frame deletion or frame repetition
// - full, empty, slip enables: one enables, zero disables, read/write, reset zero
// - activation state bit reads one while enabled detection sees the activation code
// - deactivation state bit reads one while enabled detection sees the deactivation code
// - activation change flag sets on start and stop of detection, clears on read
// - deactivation change flag sets on start and stop of detection, clears on read
// - upper four bits of the loopback status register are reserved, read zero
// - slip status clears on read and reports slips since the previous read
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`include "rsl_defines.svh"

module rsl_irq_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // receive elastic store frame events
  input  wire logic        rx_wr_frame,
  input  wire logic        rx_rd_frame,
  output logic             rx_frame_discard,
  output logic             rx_frame_replay,
  // loopback code matches from the receive framer
  input  wire logic        loop_up_match,
  input  wire logic        loop_down_match,
  // interrupt
  output logic             irq
);
  import rsl_pkg::*;

  // register state
  rsl_slip_bits_t slip_stat;
  rsl_slip_bits_t slip_buffer_irq_enable;
  logic [1:0]     loop_change;
  logic [1:0]     loop_irq_en;
  logic [1:0]     loop_ctrl;

  // event wires from the leaves
  logic full_evt;
  logic empty_evt;
  logic discard_evt;
  logic replay_evt;
  logic loop_up_code_present;
  logic loop_down_code_present;
  logic up_change_evt;
  logic down_change_evt;

  // apb phase decode
  rsl_sel_t       rsel;
  rsl_sel_t       sel_q;
  logic           setup;
  logic           access;
  logic           wr_low;
  rsl_slip_bits_t slip_clr;
  logic [1:0]     loop_clr;
  rsl_slip_bits_t slip_set;
  logic [1:0]     loop_set;
  rsl_slip_bits_t next_slip_stat;
  logic [1:0]     next_loop_change;
  rsl_slip_bits_t next_slip_buffer_irq_enable;
  logic [1:0]     next_loop_irq_en;
  rsl_loop_bits_t loop_status_view;
  logic [31:0]    next_prdata;

  rsl_slip_ctrl u_slip (
    .clk           (clk),
    .rstn          (rstn),
    .wr_frame      (rx_wr_frame),
    .rd_frame      (rx_rd_frame),
    .full_evt      (full_evt),
    .empty_evt     (empty_evt),
    .frame_discard (discard_evt),
    .frame_replay  (replay_evt)
  );

  rsl_code_track u_up (
    .clk        (clk),
    .rstn       (rstn),
    .code_match (loop_up_match),
    .det_en     (loop_ctrl[`RSL_UP_DET_EN_BIT]),
    .present    (loop_up_code_present),
    .change     (up_change_evt)
  );

  rsl_code_track u_down (
    .clk        (clk),
    .rstn       (rstn),
    .code_match (loop_down_match),
    .det_en     (loop_ctrl[`RSL_DOWN_DET_EN_BIT]),
    .present    (loop_down_code_present),
    .change     (down_change_evt)
  );

  always_comb begin
    rsel   = rsl_decode(paddr);
    setup  = psel && !penable;
    access = psel && penable && pready;
    wr_low = access && pwrite && pstrb[0] && !pslverr;
  end

  // only bits already shown in prdata are cleared, so a late event survives
  always_comb begin
    slip_clr = '0;
    loop_clr = '0;
    if (access && !pwrite && (sel_q == RSL_SEL_SLIP_STAT)) begin
      slip_clr = prdata[2:0];
    end
    if (access && !pwrite && (sel_q == RSL_SEL_LOOP_STAT)) begin
      loop_clr = prdata[1:0];
    end
  end

  always_comb begin
    slip_set                 = '0;
    slip_set[`RSL_FULL_BIT]  = full_evt;
    slip_set[`RSL_EMPTY_BIT] = empty_evt;
    slip_set[`RSL_SLIP_BIT]  = discard_evt || replay_evt;
    loop_set                 = {up_change_evt, down_change_evt};
    // set wins over the read clear
    next_slip_stat           = (slip_stat & ~slip_clr) | slip_set;
    next_loop_change         = (loop_change & ~loop_clr) | loop_set;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slip_stat <= '0;
    end else begin
      slip_stat <= next_slip_stat;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loop_change <= '0;
    end else begin
      loop_change <= next_loop_change;
    end
  end

  // enables as they stand after this edge, so irq never lags a mask write
  always_comb begin
    next_slip_buffer_irq_enable = slip_buffer_irq_enable;
    next_loop_irq_en            = loop_irq_en;
    if (wr_low && (sel_q == RSL_SEL_SLIP_EN)) begin
      next_slip_buffer_irq_enable = pwdata[2:0];
    end
    if (wr_low && (sel_q == RSL_SEL_LOOP_EN)) begin
      next_loop_irq_en = pwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slip_buffer_irq_enable <= `RSL_SLIP_EN_RST;
      loop_irq_en            <= `RSL_LOOP_EN_RST;
      loop_ctrl              <= `RSL_LOOP_CTRL_RST;
    end else if (wr_low) begin
      if (sel_q == RSL_SEL_SLIP_EN) begin
        slip_buffer_irq_enable <= pwdata[2:0];
      end
      if (sel_q == RSL_SEL_LOOP_EN) begin
        loop_irq_en <= pwdata[1:0];
      end
      if (sel_q == RSL_SEL_LOOP_CTRL) begin
        loop_ctrl <= pwdata[1:0];
      end
    end
  end

  always_comb begin
    loop_status_view = {loop_up_code_present, loop_down_code_present, loop_change};
    next_prdata      = 32'h0000_0000;
    unique case (rsel)
      RSL_SEL_SLIP_STAT: next_prdata = {29'h0000_0000, slip_stat};
      RSL_SEL_SLIP_EN:   next_prdata = {29'h0000_0000, slip_buffer_irq_enable};
      RSL_SEL_LOOP_STAT: next_prdata = {28'h000_0000, loop_status_view};
      RSL_SEL_LOOP_EN:   next_prdata = {30'h0000_0000, loop_irq_en};
      RSL_SEL_LOOP_CTRL: next_prdata = {30'h0000_0000, loop_ctrl};
      RSL_SEL_NONE:      next_prdata = 32'h0000_0000;
    endcase
  end

  // answer prepared at setup; the first access edge completes the transfer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      sel_q   <= RSL_SEL_NONE;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= rsel == RSL_SEL_NONE;
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      sel_q   <= rsel;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      sel_q   <= RSL_SEL_NONE;
    end
  end

  // slip actions towards the store datapath
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_frame_discard <= 1'b0;
      rx_frame_replay  <= 1'b0;
    end else begin
      rx_frame_discard <= discard_evt;
      rx_frame_replay  <= replay_evt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_slip_stat & next_slip_buffer_irq_enable) || |(next_loop_change & next_loop_irq_en);
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic full_store;
  logic empty_store;
  assign full_store  = u_slip.occ == `RSL_SB_FRAMES;
  assign empty_store = u_slip.occ == 2'h0;

  property p_full_sets;
    full_evt |=> slip_stat[`RSL_FULL_BIT];
  endproperty
  a_full_sets: assert property (p_full_sets) else $error("full event lost");

  property p_discard;
    (rx_wr_frame && !rx_rd_frame && full_store) |=> ##1 (rx_frame_discard && slip_stat[`RSL_SLIP_BIT]);
  endproperty
  a_discard: assert property (p_discard) else $error("write into full store did not discard");

  property p_replay;
    (rx_rd_frame && !rx_wr_frame && empty_store) |=> ##1 (rx_frame_replay && slip_stat[`RSL_SLIP_BIT]);
  endproperty
  a_replay: assert property (p_replay) else $error("read from empty store did not replay");

  property p_empty_sets;
    (rx_rd_frame && !rx_wr_frame && (u_slip.occ == 2'h1)) |=> ##1 slip_stat[`RSL_EMPTY_BIT];
  endproperty
  a_empty_sets: assert property (p_empty_sets) else $error("empty event lost");

  property p_slip_cause;
    $rose(slip_stat[`RSL_SLIP_BIT]) |-> $past(discard_evt || replay_evt);
  endproperty
  a_slip_cause: assert property (p_slip_cause) else $error("slip bit set without a slip");

  property p_enable_write;
    (access && pwrite && pstrb[0] && (sel_q == RSL_SEL_SLIP_EN)) |=> slip_buffer_irq_enable == $past(pwdata[2:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("slip enable write not stored");

  property p_up_present;
    ##1 loop_up_code_present == $past(loop_up_match && loop_ctrl[`RSL_UP_DET_EN_BIT]);
  endproperty
  a_up_present: assert property (p_up_present) else $error("activation state wrong");

  property p_down_present;
    ##1 loop_down_code_present == $past(loop_down_match && loop_ctrl[`RSL_DOWN_DET_EN_BIT]);
  endproperty
  a_down_present: assert property (p_down_present) else $error("deactivation state wrong");

  property p_up_change;
    $changed(loop_up_code_present) |=> loop_change[1];
  endproperty
  a_up_change: assert property (p_up_change) else $error("activation change not flagged");

  property p_down_change;
    $changed(loop_down_code_present) |=> loop_change[0];
  endproperty
  a_down_change: assert property (p_down_change) else $error("deactivation change not flagged");

  property p_reserved;
    (pready && (sel_q == RSL_SEL_LOOP_STAT)) |-> prdata[31:4] == 28'h000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved loop status bits not zero");

  property p_read_clear;
    (access && !pwrite && (sel_q == RSL_SEL_SLIP_STAT) && !full_evt && !empty_evt && !discard_evt && !replay_evt)
      |=> (slip_stat & $past(prdata[2:0])) == 3'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("slip status not cleared by read");

  property p_irq;
    ##1 irq == (|(slip_stat & slip_buffer_irq_enable) || |(loop_change & loop_irq_en));
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow masked status");

  property p_ready_one_cycle;
    pready |=> !pready;
  endproperty
  a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("pready held beyond one cycle");

  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

  property p_loop_en_write;
    (access && pwrite && pstrb[0] && (sel_q == RSL_SEL_LOOP_EN)) |=> loop_irq_en == $past(pwdata[1:0]);
  endproperty
  a_loop_en_write: assert property (p_loop_en_write) else $error("loop enable write not stored");

  property p_change_clear;
    (access && !pwrite && (sel_q == RSL_SEL_LOOP_STAT) && !up_change_evt && !down_change_evt)
      |=> (loop_change & $past(prdata[1:0])) == 2'h0;
  endproperty
  a_change_clear: assert property (p_change_clear) else $error("change flags not cleared by read");

  c_discard:   cover property (rx_frame_discard ##1 irq);
  c_replay:    cover property (rx_frame_replay);
  c_up_change: cover property ($rose(loop_up_code_present) ##[1:20] $fell(loop_up_code_present));
  c_read_clr:  cover property (access && !pwrite && (sel_q == RSL_SEL_SLIP_STAT) && (prdata[2:0] != 3'h0));

endmodule : rsl_irq_top

// ---- test/rx_slip_loopback_irq_test.sv ----
// self-checking bench for the receive slip / loopback code interrupt block
// assumes rsl_defines.svh on the include path and the design files compiled first
`timescale 1ns/10ps
`include "rsl_defines.svh"

module rx_slip_loopback_irq_test;
  import rsl_pkg::*;

  typedef struct {
    logic [11:0] a;
    logic [31:0] w;
    logic [3:0]  s;
    logic [31:0] r;
    logic        e;
  } rsl_row_t;

  logic        clk;
  logic        rstn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_wr_frame;
  logic        rx_rd_frame;
  logic        rx_frame_discard;
  logic        rx_frame_replay;
  logic        loop_up_match;
  logic        loop_down_match;
  logic        irq;
  int          bad_count;
  int          n_compared;
  int          n_discard;
  int          n_replay;
  logic [31:0] rdv;
  logic        errv;
  rsl_row_t    rows [9];

  rsl_irq_top u_dut (
    .clk              (clk),
    .rstn             (rstn),
    .paddr            (paddr),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .pwdata           (pwdata),
    .pstrb            (pstrb),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .rx_wr_frame      (rx_wr_frame),
    .rx_rd_frame      (rx_rd_frame),
    .rx_frame_discard (rx_frame_discard),
    .rx_frame_replay  (rx_frame_replay),
    .loop_up_match    (loop_up_match),
    .loop_down_match  (loop_down_match),
    .irq              (irq)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // cycles of slip pulses, so a pulse longer than one cycle shows up
  always @(posedge clk) begin
    if (rx_frame_discard === 1'b1) n_discard++;
    if (rx_frame_replay === 1'b1) n_replay++;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // one apb transfer; waits for pready, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    check("pready_wait", n, 1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf, rdv, errv);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf, rdv, errv);
    check(nm, rdv, exp);
  endtask : rd_chk

  // frame event pulses held for n cycles, then time for status and irq to land
  task automatic frames(input logic w, input logic r, input int n);
    @(posedge clk);
    rx_wr_frame <= w;
    rx_rd_frame <= r;
    repeat (n) @(posedge clk);
    rx_wr_frame <= 1'b0;
    rx_rd_frame <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : frames

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, rx_wr_frame, rx_rd_frame, loop_up_match, loop_down_match} = '0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    bad_count = 0;
    n_compared = 0;
    n_discard = 0;
    n_replay = 0;
    rows[0] = '{`RSL_SLIP_EN_OFS, 32'hffffffff, 4'hf, 32'h7, 1'b0};
    rows[1] = '{`RSL_SLIP_EN_OFS, 32'h7, 4'he, 32'h7, 1'b0};
    rows[2] = '{`RSL_SLIP_EN_OFS, 32'h0, 4'hf, 32'h0, 1'b0};
    rows[3] = '{`RSL_LOOP_EN_OFS, 32'hff, 4'hf, 32'h3, 1'b0};
    rows[4] = '{`RSL_LOOP_CTRL_OFS, 32'h3, 4'hf, 32'h3, 1'b0};
    rows[5] = '{`RSL_SLIP_STAT_OFS, 32'hff, 4'hf, 32'h0, 1'b0};
    rows[6] = '{`RSL_LOOP_STAT_OFS, 32'hff, 4'hf, 32'h0, 1'b0};
    rows[7] = '{12'h014, 32'h1, 4'hf, 32'h0, 1'b1};
    rows[8] = '{12'h0fc, 32'h1, 4'hf, 32'h0, 1'b1};
    repeat (20) @(posedge clk);
    check("irq_in_reset", {31'h0, irq}, 32'h0);
    rstn <= 1'b1;
    rd_chk("slip_en_rst", `RSL_SLIP_EN_OFS, 32'h0);
    rd_chk("loop_stat_rst", `RSL_LOOP_STAT_OFS, 32'h0);
    $display("test reset done");

    for (int i = 0; i < 9; i++) begin
      apb(1'b1, rows[i].a, rows[i].w, rows[i].s, rdv, errv);
      check("write_err", {31'h0, errv}, {31'h0, rows[i].e});
      apb(1'b0, rows[i].a, 32'h0, 4'hf, rdv, errv);
      check("read_data", rdv, rows[i].r);
      check("read_err", {31'h0, errv}, {31'h0, rows[i].e});
    end
    $display("test register table done");

    frames(1'b1, 1'b0, 1);
    check("irq_masked", {31'h0, irq}, 32'h0);
    rd_chk("full_stat", `RSL_SLIP_STAT_OFS, 32'h4);
    rd_chk("stat_cleared", `RSL_SLIP_STAT_OFS, 32'h0);
    wr(`RSL_SLIP_EN_OFS, 32'h7);
    frames(1'b1, 1'b0, 1);
    check("discard_cycles", n_discard, 1);
    check("irq_slip", {31'h0, irq}, 32'h1);
    rd_chk("slip_stat", `RSL_SLIP_STAT_OFS, 32'h1);
    repeat (2) @(posedge clk);
    check("irq_after_clear", {31'h0, irq}, 32'h0);
    $display("test full and discard done");

    // two back-to-back reads empty the store
    frames(1'b0, 1'b1, 2);
    rd_chk("empty_stat", `RSL_SLIP_STAT_OFS, 32'h2);
    frames(1'b0, 1'b1, 1);
    check("replay_cycles", n_replay, 1);
    rd_chk("replay_stat", `RSL_SLIP_STAT_OFS, 32'h1);
    frames(1'b1, 1'b1, 1);
    rd_chk("no_slip_both", `RSL_SLIP_STAT_OFS, 32'h0);
    // three writes in a row from empty: fill, then one discard
    frames(1'b1, 1'b0, 3);
    check("discard_run", n_discard, 2);
    rd_chk("fill_and_slip", `RSL_SLIP_STAT_OFS, 32'h5);
    $display("test empty and replay done");

    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      loop_up_match   <= (k == 0);
      loop_down_match <= (k == 1);
      repeat (4) @(posedge clk);
      check("irq_loop", {31'h0, irq}, 32'h1);
      rd_chk("loop_start", `RSL_LOOP_STAT_OFS, (32'h8 >> k) | (32'h2 >> k));
      rd_chk("loop_held", `RSL_LOOP_STAT_OFS, 32'h8 >> k);
      @(posedge clk);
      loop_up_match   <= 1'b0;
      loop_down_match <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk("loop_stop", `RSL_LOOP_STAT_OFS, 32'h2 >> k);
    end
    wr(`RSL_LOOP_CTRL_OFS, 32'h0);
    @(posedge clk);
    loop_up_match   <= 1'b1;
    loop_down_match <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("loop_disabled", `RSL_LOOP_STAT_OFS, 32'h0);
    check("irq_idle", {31'h0, irq}, 32'h0);
    $display("test loopback codes done");

    // masking a pending slip drops irq at once; a mid-run reset clears the registers and sets the store back to one frame
    frames(1'b1, 1'b0, 1);
    check("irq_pending", {31'h0, irq}, 32'h1);
    wr(`RSL_SLIP_EN_OFS, 32'h0);
    @(posedge clk);
    check("irq_mask_drop", {31'h0, irq}, 32'h0);
    rstn <= 1'b0;
    @(posedge clk);
    check("irq_mid_reset", {31'h0, irq}, 32'h0);
    rstn <= 1'b1;
    rd_chk("loop_en_mid_rst", `RSL_LOOP_EN_OFS, 32'h0);
    frames(1'b1, 1'b0, 1);
    check("no_discard_half", n_discard, 3);
    rd_chk("full_mid_rst", `RSL_SLIP_STAT_OFS, 32'h4);
    $display("test mask and mid-run reset done");
    tally_and_finish();
  end

endmodule : rx_slip_loopback_irq_test
